// >>> core/dual_buck_protect_sequencer.sv
// Dual buck supervisor: soft-start, sequencing, protection, power-ok
//
// Local design decisions: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module dual_buck_protect_sequencer
    import seq_pkg::*;
#(
    parameter int unsigned STAGE_CYCLES = SS_STAGE_CYCLES,
    parameter int unsigned BLANK_CYCLES = UV_BLANK_CYCLES
) (
    input  wire logic          sys_clk,
    input  wire logic          rst,
    input  wire supply_sense_t supply_sense,
    input  wire chan_sense_t   chan_sense [2],
    output var  chan_drive_t   chan_drive [2],
    output var  logic          power_ok_out,
    output var  logic          power_ok_oe,
    input  wire logic [3:0]    avs_address,
    input  wire logic          avs_read,
    input  wire logic          avs_write,
    input  wire logic [31:0]   avs_writedata,
    output var  logic [31:0]   avs_readdata,
    output var  logic          avs_waitrequest
);

    localparam int unsigned STAGE_W = $clog2(STAGE_CYCLES + 1);
    localparam int unsigned BLANK_W = $clog2(BLANK_CYCLES + SEQ_WINDOW_CYCLES + 1);
    localparam int unsigned OV_W    = $clog2(OV_FILTER_CYCLES + 1);
    localparam logic [BLANK_W-1:0] BLANK_MAX = BLANK_W'(BLANK_CYCLES);
    localparam logic [BLANK_W-1:0] WINDOW    = BLANK_W'(SEQ_WINDOW_CYCLES);
    localparam logic [STAGE_W-1:0] STAGE_END = STAGE_W'(STAGE_CYCLES - 1);
    localparam logic [OV_W-1:0]    OV_END    = OV_W'(OV_FILTER_CYCLES - 1);

    if (STAGE_CYCLES < 1 || BLANK_CYCLES < SEQ_WINDOW_CYCLES) begin : g_chk
        $error("Stage or blanking count too small");
    end

    // Pin synchronisers: first stage feeds only the second
    supply_sense_t supply_meta_reg;
    supply_sense_t supply_reg;
    supply_sense_t supply_prev_reg;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            supply_meta_reg <= '0;
            supply_reg      <= '0;
            supply_prev_reg <= '0;
        end else begin
            supply_meta_reg <= supply_sense;
            supply_reg      <= supply_meta_reg;
            supply_prev_reg <= supply_reg;
        end
    end

    logic       main_rise;
    logic [1:0] en_rise;
    logic       latch_clear;
    logic       shutdown;
    logic       lockout;
    logic       run_ok;

    assign main_rise   = supply_reg.main_en & ~supply_prev_reg.main_en;
    assign en_rise     = supply_reg.ch_en & ~supply_prev_reg.ch_en;
    assign latch_clear = main_rise | (|en_rise);
    assign shutdown    = ~supply_reg.main_en & ~(|supply_reg.ch_en);
    assign lockout     = supply_reg.five_uv & supply_reg.three_uv;

    // Control register
    logic [1:0] ctrl_reg;
    logic       ovp_en;
    logic       uvp_en;

    assign ovp_en = ctrl_reg[CTRL_OVP_BIT];
    assign uvp_en = ctrl_reg[CTRL_UVP_BIT];

    // Fault latches; a new trip in the clearing cycle wins
    logic       ov_latch_reg;
    logic       uv_latch_reg;
    logic       thermal_reg;
    logic [1:0] ov_hit;
    logic [1:0] uv_hit;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ov_latch_reg <= 1'b0;
        end else if (|ov_hit) begin
            ov_latch_reg <= 1'b1;
        end else if (latch_clear) begin
            ov_latch_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            uv_latch_reg <= 1'b0;
        end else if (|uv_hit) begin
            uv_latch_reg <= 1'b1;
        end else if (latch_clear) begin
            uv_latch_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            thermal_reg <= 1'b0;
        end else if (supply_reg.over_temp) begin
            thermal_reg <= 1'b1;
        end else if (latch_clear) begin
            thermal_reg <= 1'b0;
        end
    end

    // Lockout is not latched, so channels restart once it clears
    assign run_ok = ~shutdown & ~lockout & ~thermal_reg;

    chan_state_t       state_q  [2];
    logic [BLANK_W-1:0] age_q   [2];
    logic [1:0]        good_in;
    logic [1:0]        low_in;
    logic [1:0]        run_drive;

    for (genvar c = 0; c < 2; c++) begin : g_ch
        chan_sense_t        sense_meta_reg;
        chan_sense_t        sense_reg;
        chan_state_t        state_next;
        logic [STAGE_W-1:0] stage_cnt_reg;
        logic [2:0]         stage_reg;
        logic [OV_W-1:0]    ov_cnt_reg;
        logic [1:0]         target_reg;
        logic               powered;
        logic               ss_done;
        logic               hold_seq;
        chan_drive_t        drive_next;

        always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
                sense_meta_reg <= '0;
                sense_reg      <= '0;
            end else begin
                sense_meta_reg <= chan_sense[c];
                sense_reg      <= sense_meta_reg;
            end
        end

        assign powered  = (state_q[c] == CH_SOFT) || (state_q[c] == CH_RUN);
        assign ss_done  = (stage_reg == 3'(SS_STAGES - 1))
                          && (stage_cnt_reg == STAGE_END);
        // Near-simultaneous enables start together; a later one waits
        assign hold_seq = (state_q[1-c] == CH_SOFT)
                          && (age_q[1-c] >= WINDOW);
        assign good_in[c] = sense_reg.good;
        assign low_in[c]  = sense_reg.low;
        assign run_drive[c] = (state_q[c] == CH_RUN) && drive_next.switching;

        always_comb begin
            state_next = state_q[c];
            case (state_q[c])
                CH_OFF: begin
                    if (run_ok && supply_reg.ch_en[c]) begin
                        state_next = CH_WAIT;
                    end
                end
                CH_WAIT: begin
                    if (!run_ok || !supply_reg.ch_en[c]) begin
                        state_next = CH_OFF;
                    end else if (!hold_seq) begin
                        state_next = CH_SOFT;
                    end
                end
                CH_SOFT, CH_RUN: begin
                    if (ov_latch_reg || uv_latch_reg) begin
                        state_next = CH_FAULT;
                    end else if (!supply_reg.ch_en[c]) begin
                        state_next = CH_DISCH;
                    end else if (!run_ok) begin
                        state_next = CH_OFF;
                    end else if (state_q[c] == CH_SOFT && ss_done) begin
                        state_next = CH_RUN;
                    end
                end
                CH_FAULT: begin
                    if (!ov_latch_reg && !uv_latch_reg) begin
                        state_next = CH_OFF;
                    end
                end
                CH_DISCH: begin
                    if (thermal_reg || !sense_reg.resid) begin
                        state_next = CH_OFF;
                    end else if (run_ok && supply_reg.ch_en[c]) begin
                        state_next = CH_WAIT;
                    end
                end
                default: state_next = CH_OFF;
            endcase
        end

        always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
                state_q[c] <= CH_OFF;
            end else begin
                state_q[c] <= state_next;
            end
        end

        // Equal-length current-limit stages during soft-start
        always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
                stage_cnt_reg <= '0;
                stage_reg     <= '0;
            end else if (state_q[c] != CH_SOFT) begin
                stage_cnt_reg <= '0;
                stage_reg     <= '0;
            end else if (stage_cnt_reg == STAGE_END) begin
                stage_cnt_reg <= '0;
                if (stage_reg != 3'(SS_STAGES - 1)) begin
                    stage_reg <= stage_reg + 3'h1;
                end
            end else begin
                stage_cnt_reg <= stage_cnt_reg + STAGE_W'(1);
            end
        end

        // Time since soft-start began, saturating at blanking end
        always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
                age_q[c] <= '0;
            end else if (!powered) begin
                age_q[c] <= '0;
            end else if (age_q[c] < BLANK_MAX) begin
                age_q[c] <= age_q[c] + BLANK_W'(1);
            end
        end

        assign uv_hit[c] = powered && uvp_en && sense_reg.uv
                           && (age_q[c] >= BLANK_MAX);

        // Glitch filter: trip only after the full persistence time
        always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
                ov_cnt_reg <= '0;
            end else if (!(powered && ovp_en && sense_reg.ov)) begin
                ov_cnt_reg <= '0;
            end else if (ov_cnt_reg != OV_END) begin
                ov_cnt_reg <= ov_cnt_reg + OV_W'(1);
            end
        end

        assign ov_hit[c] = powered && ovp_en && sense_reg.ov
                           && (ov_cnt_reg == OV_END);

        // Strap is sampled as the channel starts from off, after reset release
        always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
                target_reg <= TGT_ADJ;
            end else if (state_q[c] == CH_OFF && state_next == CH_WAIT) begin
                if (sense_reg.fb_gnd) begin
                    target_reg <= TGT_3V3;
                end else if (sense_reg.fb_rail) begin
                    target_reg <= TGT_5V;
                end else begin
                    target_reg <= TGT_ADJ;
                end
            end
        end

        always_comb begin
            drive_next        = '0;
            drive_next.target = target_reg;
            if (state_q[c] == CH_SOFT) begin
                drive_next.ilim_step = stage_reg + 3'h1;
            end else if (state_q[c] == CH_RUN) begin
                drive_next.ilim_step = ILIM_FULL_STEP;
            end
            if (thermal_reg || shutdown && !sense_reg.resid) begin
                drive_next.high_side_drive_off = 1'b1;
                drive_next.low_side_drive_off  = 1'b1;
            end else if (ov_latch_reg) begin
                drive_next.high_side_drive_off = 1'b1;
                drive_next.low_side_drive_on   = 1'b1;
            end else if (uv_latch_reg) begin
                drive_next.high_side_drive_off = 1'b1;
                drive_next.low_side_drive_off  = 1'b1;
                drive_next.discharge           = 1'b1;
            end else if (powered) begin
                drive_next.switching = 1'b1;
            end else begin
                drive_next.high_side_drive_off = 1'b1;
                drive_next.low_side_drive_off  = 1'b1;
                drive_next.discharge = (state_q[c] == CH_DISCH);
            end
            // Channel one feeds the five-volt rail, two the three-volt
            drive_next.switchover = !thermal_reg && state_q[c] == CH_RUN
                                    && sense_reg.swover;
            drive_next.ldo_en = supply_reg.main_en && !thermal_reg
                                && !drive_next.switchover;
        end

        always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
                chan_drive[c] <= '{high_side_drive_off: 1'b1,
                                   low_side_drive_off: 1'b1,
                                   target: TGT_ADJ,
                                   default: 1'b0};
            end else begin
                chan_drive[c] <= drive_next;
            end
        end
    end

    // Power-ok: hysteresis between 92.5% release and 10% low drop
    logic all_run;
    logic pg_release_reg;

    assign all_run = (state_q[0] == CH_RUN) && (state_q[1] == CH_RUN);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pg_release_reg <= 1'b0;
        end else if (!all_run) begin
            pg_release_reg <= 1'b0;
        end else if (pg_release_reg) begin
            pg_release_reg <= ~(|low_in);
        end else begin
            pg_release_reg <= &good_in;
        end
    end

    // Open drain: the pin level is never driven high
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            power_ok_out <= 1'b0;
            power_ok_oe  <= 1'b1;
        end else begin
            power_ok_out <= 1'b0;
            // Gated by this cycle's drives so a trip pulls it low at once
            power_ok_oe  <= ~(pg_release_reg & (&run_drive));
        end
    end

    // Avalon slave: one wait cycle on every access
    logic access;
    logic wr_take;

    assign access  = avs_read | avs_write;
    assign wr_take = avs_write & ~avs_waitrequest;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= ~(access & avs_waitrequest);
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctrl_reg <= CTRL_RESET;
        end else if (wr_take && avs_address == REG_CTRL) begin
            ctrl_reg <= avs_writedata[1:0];
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            avs_readdata <= '0;
        end else if (avs_read && avs_waitrequest) begin
            case (avs_address)
                REG_CTRL:   avs_readdata <= {30'h0, ctrl_reg};
                REG_STATUS: avs_readdata <= {20'h0, pg_release_reg,
                                             thermal_reg, lockout,
                                             uv_latch_reg, ov_latch_reg,
                                             shutdown, state_q[1],
                                             state_q[0]};
                REG_LIMIT:  avs_readdata <= {22'h0,
                                             chan_drive[1].target,
                                             chan_drive[1].ilim_step,
                                             chan_drive[0].target,
                                             chan_drive[0].ilim_step};
                default:    avs_readdata <= '0;
            endcase
        end
    end

endmodule // dual_buck_protect_sequencer

`default_nettype wire

// >>> core/seq_pkg.sv
// Constants and types for the dual buck protection sequencer
package seq_pkg;

    localparam int unsigned CLK_MHZ          = 20;
    localparam int unsigned SS_STAGES        = 5;
    localparam int unsigned SS_TOTAL_US      = 2000;
    localparam int unsigned SS_STAGE_US      = SS_TOTAL_US / SS_STAGES;
    localparam int unsigned SS_STAGE_CYCLES  = SS_STAGE_US * CLK_MHZ;
    localparam int unsigned UV_BLANK_US      = 3000;
    localparam int unsigned UV_BLANK_CYCLES  = UV_BLANK_US * CLK_MHZ;
    localparam int unsigned OV_FILTER_US     = 10;
    localparam int unsigned OV_FILTER_CYCLES = OV_FILTER_US * CLK_MHZ;
    localparam int unsigned SEQ_WINDOW_US    = 60;
    localparam int unsigned SEQ_WINDOW_CYCLES = SEQ_WINDOW_US * CLK_MHZ;

    localparam logic [2:0] ILIM_FULL_STEP = 3'h5;

    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_LIMIT  = 4'h8;

    localparam int unsigned CTRL_OVP_BIT = 0;
    localparam int unsigned CTRL_UVP_BIT = 1;
    localparam logic [1:0]  CTRL_RESET   = 2'h3;

    localparam logic [1:0] TGT_ADJ = 2'h0;
    localparam logic [1:0] TGT_3V3 = 2'h1;
    localparam logic [1:0] TGT_5V  = 2'h2;

    typedef enum logic [2:0] {
        CH_OFF,
        CH_WAIT,
        CH_SOFT,
        CH_RUN,
        CH_FAULT,
        CH_DISCH
    } chan_state_t;

    // Comparator flags of one output from the analog front end
    typedef struct packed {
        logic ov;       // above 111% of setpoint
        logic uv;       // below 70% of setpoint
        logic good;     // above 92.5% of nominal
        logic low;      // 10% below nominal
        logic swover;   // above switchover threshold
        logic resid;    // residual charge still on output
        logic fb_gnd;   // feedback strap tied to ground
        logic fb_rail;  // feedback strap tied to five-volt rail
    } chan_sense_t;

    typedef struct packed {
        logic       main_en;
        logic [1:0] ch_en;
        logic       five_uv;    // five-volt rail below 4.2 V
        logic       three_uv;   // three-volt rail below 2.5 V
        logic       over_temp;  // die above 150 C
    } supply_sense_t;

    typedef struct packed {
        logic       switching;
        logic       high_side_drive_off;
        logic       low_side_drive_on;
        logic       low_side_drive_off;
        logic       discharge;
        logic       switchover;
        logic       ldo_en;
        logic [2:0] ilim_step;
        logic [1:0] target;
    } chan_drive_t;

endpackage

// >>> verif/dual_buck_protect_sequencer_props.sv
// Port-level assertions for the dual buck sequencer
`timescale 1ns/1ps
`default_nettype none
module dual_buck_protect_sequencer_props
    import seq_pkg::*;
(
    input wire logic          sys_clk,
    input wire logic          rst,
    input wire supply_sense_t supply_sense,
    input wire chan_sense_t   chan_sense [2],
    input wire chan_drive_t   chan_drive [2],
    input wire logic          power_ok_out,
    input wire logic          power_ok_oe
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic [7:0]  quiet_reg;
    logic        ov_any;
    chan_drive_t d0;
    chan_drive_t d1;
    assign ov_any = chan_sense[0].ov | chan_sense[1].ov;
    assign d0 = chan_drive[0];
    assign d1 = chan_drive[1];
    // The over-voltage latch is judged only once all supply sense pins (enables, undervoltage, over-temperature) have settled
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst)
            quiet_reg <= 8'h00;
        else if (!$stable(supply_sense))
            quiet_reg <= 8'h00;
        else if (quiet_reg != 8'hff)
            quiet_reg <= quiet_reg + 8'h01;
    end
    sequence lock_held;
        (supply_sense.five_uv && supply_sense.three_uv) [*5];
    endsequence
    sequence hot_held;
        supply_sense.over_temp [*5];
    endsequence
    sequence sag_held;
        (chan_sense[0].low || chan_sense[1].low) [*6];
    endsequence
    sequence ov_kept;
        quiet_reg > 8'h08 ##0 $past(d0.low_side_drive_on);
    endsequence
    ilim_range_a: assert property (d0.ilim_step <= ILIM_FULL_STEP &&
        d1.ilim_step <= ILIM_FULL_STEP) else $error("limit step too high");
    pok_data_a: assert property (power_ok_out == 1'b0)
        else $error("power ok data not low");
    pok_release_a: assert property (!power_ok_oe |-> d0.switching &&
        d1.switching && d0.ilim_step == ILIM_FULL_STEP &&
        d1.ilim_step == ILIM_FULL_STEP) else $error("early power ok");
    pok_drop_a: assert property (sag_held |-> power_ok_oe)
        else $error("power ok kept on low output");
    ov_filter_a: assert property ($rose(d0.low_side_drive_on) |->
        $past(ov_any, 150)) else $error("over-voltage glitch tripped");
    ov_drive_a: assert property (d0.low_side_drive_on |->
        d0.high_side_drive_off && !d0.low_side_drive_off && !d0.switching
        && d1.low_side_drive_on) else $error("over-voltage drive wrong");
    ov_latch_a: assert property (ov_kept |-> d0.low_side_drive_on)
        else $error("over-voltage latch lost");
    disch_off_a: assert property (d0.discharge |->
        !d0.switching && d0.high_side_drive_off)
        else $error("switching while discharging");
    hot_off_a: assert property (hot_held |-> !d0.switching &&
        !d1.switching && !d0.ldo_en && !d1.ldo_en && !d0.discharge &&
        !d1.discharge) else $error("circuitry on when hot");
    lock_stop_a: assert property (lock_held |->
        !d0.switching && !d1.switching) else $error("switching in lockout");
    swover_gate_a: assert property (
        (!chan_sense[0].swover [*5] |-> !d0.switchover) and
        (!chan_sense[1].swover [*5] |-> !d1.switchover))
        else $error("switchover below threshold");
    swover_ldo_a: assert property ((d0.switchover |-> !d0.ldo_en) and
        (d1.switchover |-> !d1.ldo_en)) else $error("regulator on in switchover");
endmodule // dual_buck_protect_sequencer_props
`default_nettype wire

// >>> verif/seq_power_stage.sv
// Behavioural power stage and output comparators for the sequencer bench
`timescale 1ns/1ps
`default_nettype none
module seq_power_stage
    import seq_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire chan_drive_t chan_drive [2],
    input  wire logic [1:0]  strap [2],
    input  wire logic [7:0]  target [2],
    output var  chan_sense_t chan_sense [2]
);
    int vout [2] = '{0, 0};
    // Output in percent of nominal; slow slew so comparators lag the drives
    always @(posedge sys_clk) begin
        for (int i = 0; i < 2; i++) begin
            if (chan_drive[i].discharge || chan_drive[i].low_side_drive_on)
                vout[i] <= (vout[i] > 10) ? vout[i] - 10 : 0;
            else if (chan_drive[i].switching)
                vout[i] <= vout[i] + int'(vout[i] < target[i])
                           - int'(vout[i] > target[i]);
            else if (vout[i] > 0)
                vout[i] <= vout[i] - 1;
        end
    end
    always_comb begin
        for (int i = 0; i < 2; i++)
            chan_sense[i] = {vout[i] > 111, vout[i] < 70,
                             vout[i] > 92, vout[i] < 90,
                             vout[i] > 93, vout[i] > 0,
                             strap[i][0], strap[i][1]};
    end
endmodule // seq_power_stage
`default_nettype wire

// >>> verif/dual_buck_protect_sequencer_tb.sv
// Self-checking bench for the dual buck sequencer
`timescale 1ns/1ps
`default_nettype none
module dual_buck_protect_sequencer_tb
    import seq_pkg::*;
;
    localparam int unsigned STG = 8;
    logic          sys_clk = 1'b0;
    logic          rst = 1'b1;
    supply_sense_t ss = '0;
    chan_sense_t   cs [2];
    chan_drive_t   cd [2];
    logic          pok;
    logic          pok_oe;
    logic          wrq;
    logic          rd = 1'b0;
    logic          wr = 1'b0;
    logic [3:0]    adr = 4'h0;
    logic [31:0]   wdat = 32'h0;
    logic [31:0]   rdat;
    logic [31:0]   got;
    logic [1:0]    strap [2] = '{2'h2, 2'h1};
    logic [7:0]    tgt [2] = '{8'h64, 8'h64};
    int            n_mismatch = 0;
    int            tests_run = 0;
    int            seed = 32'hac6ee519;
    int            n;
    always #25 sys_clk = ~sys_clk;
    dual_buck_protect_sequencer #(.STAGE_CYCLES(STG), .BLANK_CYCLES(1300)) dut (
        .sys_clk(sys_clk), .rst(rst), .supply_sense(ss), .chan_sense(cs),
        .chan_drive(cd), .power_ok_out(pok), .power_ok_oe(pok_oe),
        .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wdat), .avs_readdata(rdat), .avs_waitrequest(wrq));
    seq_power_stage stage (.sys_clk(sys_clk), .chan_drive(cd),
        .strap(strap), .target(tgt), .chan_sense(cs));
    task automatic complete_run;
        if (n_mismatch == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int c);
        repeat (c) @(posedge sys_clk);
    endtask
    // One Avalon access; read data and waitrequest taken at the same edge
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
        int k;
        k = 0;
        adr <= a;
        wdat <= d;
        rd <= !w;
        wr <= w;
        do begin
            @(posedge sys_clk);
            k++;
        end while (wrq !== 1'b0 && k < 20);
        got = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        if (wrq !== 1'b0) begin
            n_mismatch++;
            complete_run();
        end
        @(posedge sys_clk);
    endtask
    task automatic wsw(input int c, input int lim);
        int k;
        k = 0;
        while (cd[c].switching !== 1'b1) begin
            cyc(1);
            k++;
            if (k > lim) begin
                n_mismatch++;
                complete_run();
            end
        end
    endtask
    function automatic logic [1:0] tgt_of(input logic [1:0] s);
        return s[1] ? TGT_5V : (s[0] ? TGT_3V3 : TGT_ADJ);
    endfunction
    function automatic logic [31:0] exp_lim();
        return {22'h0, tgt_of(strap[1]), ILIM_FULL_STEP,
                tgt_of(strap[0]), ILIM_FULL_STEP};
    endfunction
    initial begin
        cyc(8);
        rst <= 1'b0;
        cyc(1);
        bus(1'b0, REG_CTRL, 32'h0);
        chk(got, 32'h3);
        bus(1'b1, REG_STATUS, $random(seed));
        bus(1'b1, 4'hc, $random(seed));
        bus(1'b0, 4'hc, 32'h0);
        chk(got, 32'h0);
        bus(1'b0, REG_STATUS, 32'h0);
        chk(got, 32'h40);
        ss.main_en <= 1'b1;
        ss.ch_en <= 2'h3;
        wsw(0, 20);
        for (int s = 1; s <= 5; s++) begin
            cyc(STG / 2);
            chk({cd[1].ilim_step, cd[0].ilim_step}, s * 9);
            chk(pok_oe, 1'b1);
            cyc(STG - STG / 2);
        end
        cyc(20);
        chk(pok_oe, 1'b1);
        cyc(130);
        chk(pok_oe, 1'b0);
        bus(1'b0, REG_LIMIT, 32'h0);
        chk(got, exp_lim());
        bus(1'b0, REG_STATUS, 32'h0);
        chk(got, 32'h81b);
        chk({cd[1].switchover, cd[0].switchover, cd[1].ldo_en, cd[0].ldo_en},
            4'hc);
        tgt[1] <= 8'h55;
        cyc(40);
        chk(pok_oe, 1'b1);
        tgt[1] <= 8'h64;
        tgt[0] <= 8'h73;
        n = 20 + ($random(seed) & 63);
        cyc(n);
        tgt[0] <= 8'h64;
        cyc(250);
        chk(cd[0].low_side_drive_on, 1'b0);
        bus(1'b1, REG_CTRL, 32'h2);
        tgt[0] <= 8'h73;
        cyc(300);
        chk(cd[0].low_side_drive_on, 1'b0);
        bus(1'b1, REG_CTRL, 32'h3);
        cyc(260);
        chk({cd[1].low_side_drive_on, cd[0].low_side_drive_on,
             cd[0].high_side_drive_off}, 3'h7);
        tgt[0] <= 8'h64;
        cyc(200);
        chk({cd[0].low_side_drive_on, cd[0].low_side_drive_off}, 2'h2);
        chk({cd[1].ldo_en, cd[0].ldo_en}, 2'h3);
        bus(1'b0, REG_STATUS, 32'h0);
        chk(got[7], 1'b1);
        ss.ch_en <= 2'h1;
        cyc(5);
        ss.ch_en <= 2'h3;
        cyc(10);
        chk(cd[0].low_side_drive_on, 1'b0);
        ss.main_en <= 1'b0;
        strap[1] <= 2'h0;
        cyc(10);
        bus(1'b0, REG_STATUS, 32'h0);
        chk(got[6], 1'b0);
        ss.ch_en <= 2'h0;
        cyc(300);
        bus(1'b0, REG_STATUS, 32'h0);
        chk(got, 32'h40);
        tgt[1] <= 8'h32;
        ss.main_en <= 1'b1;
        ss.ch_en <= 2'h3;
        wsw(1, 20);
        cyc(800);
        chk(cd[1].discharge, 1'b0);
        bus(1'b0, REG_LIMIT, 32'h0);
        chk(got, exp_lim());
        cyc(700);
        chk({cd[1].discharge, cd[0].high_side_drive_off,
             cd[0].low_side_drive_off, cd[0].switching}, 4'he);
        tgt[1] <= 8'h64;
        ss.ch_en <= 2'h0;
        cyc(300);
        ss.ch_en <= 2'h1;
        wsw(0, 20);
        cyc(150);
        chk(cd[1].switching, 1'b0);
        ss.ch_en <= 2'h0;
        cyc(6);
        chk(cd[0].discharge, 1'b1);
        cyc(40);
        chk(cd[0].discharge, 1'b0);
        ss.ch_en <= 2'h3;
        wsw(0, 20);
        cyc(150);
        ss.five_uv <= 1'b1;
        cyc(10);
        chk(cd[0].switching, 1'b1);
        ss.three_uv <= 1'b1;
        cyc(10);
        chk(cd[0].switching, 1'b0);
        ss.five_uv <= 1'b0;
        ss.three_uv <= 1'b0;
        wsw(0, 20);
        chk(cd[0].switching, 1'b1);
        ss.over_temp <= 1'b1;
        cyc(10);
        chk({cd[0].switching, cd[0].ldo_en, cd[1].ldo_en}, 3'h0);
        ss.over_temp <= 1'b0;
        cyc(20);
        chk(cd[0].switching, 1'b0);
        ss.main_en <= 1'b0;
        cyc(5);
        ss.main_en <= 1'b1;
        wsw(0, 30);
        chk(cd[0].switching, 1'b1);
        complete_run();
    end
    // Hang guard
    initial begin
        cyc(100000);
        n_mismatch++;
        complete_run();
    end
endmodule // dual_buck_protect_sequencer_tb
bind dual_buck_protect_sequencer dual_buck_protect_sequencer_props u_props (
    .sys_clk(sys_clk), .rst(rst), .supply_sense(supply_sense),
    .chan_sense(chan_sense), .chan_drive(chan_drive),
    .power_ok_out(power_ok_out), .power_ok_oe(power_ok_oe));
`default_nettype wire
